// ---- shared/bcsr_pkg.sv ----
// Constants for the bridge status, class and line size configuration registers
package bcsr_pkg;
  // ==========================================
  // Configuration byte offsets
  localparam logic [7:0]  OFF_COMMAND     = 8'h04;
  localparam logic [7:0]  OFF_STATUS      = 8'h06;
  localparam logic [7:0]  OFF_CLASS       = 8'h08;
  localparam logic [7:0]  OFF_LINE_SIZE   = 8'h0c;
  // ==========================================
  // Status bit positions
  localparam int          BIT_DET_POISON  = 15;
  localparam int          BIT_SIG_SYSERR  = 14;
  localparam int          BIT_RCV_UNSUP   = 13;
  localparam int          BIT_RCV_CABORT  = 12;
  localparam int          BIT_SIG_CABORT  = 11;
  localparam int          BIT_MST_POISON  = 8;
  localparam int          BIT_CAP_LIST    = 4;
  localparam logic [15:0] STATUS_ERR_MASK = 16'hf900;
  localparam logic [15:0] STATUS_RST      = 16'h0010;
  // ==========================================
  // Command bit positions
  localparam int          BIT_SERR_EN     = 8;
  localparam int          BIT_PARITY_EN   = 6;
  localparam logic [15:0] COMMAND_RST     = 16'h0000;
  // ==========================================
  // Class code fields
  localparam logic [7:0]  BASE_CLASS      = 8'h06;
  localparam logic [7:0]  SUB_CLASS       = 8'h04;
  localparam logic [7:0]  PROG_IF         = 8'h00;
  // ==========================================
  // Line size
  localparam logic [7:0]  LINE_SIZE_RST   = 8'h00;
  localparam logic [7:0]  LINE_SIZE_MAX   = 8'h20;
  localparam int          PREFETCH_W      = 6;
endpackage

// ---- src/bcsr_sticky.sv ----
// Sticky error flag bank, set wins over clear
`timescale 1ns/100ps
module bcsr_sticky #(
  parameter int WIDTH = 16
) (
  input  wire logic             REF_CLK,
  input  wire logic             SYS_RST,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bcsr_stk_s;

  bcsr_stk_s r;
  bcsr_stk_s next_r;

  always_comb begin
    next_r       = r;
    next_r.flags = (r.flags & ~clr) | set;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.flags;
endmodule // bcsr_sticky

// ---- src/bcsr_line_decode.sv ----
// Effective prefetch length derived from the programmed line size
`timescale 1ns/100ps
module bcsr_line_decode
  import bcsr_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic [7:0]            line_size,
  output logic      [PREFETCH_W-1:0] prefetch_dwords
);
  typedef struct packed {
    logic [PREFETCH_W-1:0] dwords;
  } bcsr_ld_s;

  bcsr_ld_s r;
  bcsr_ld_s next_r;

  function automatic logic line_ok(input logic [7:0] v);
    return !v[0] && (v <= LINE_SIZE_MAX);
  endfunction

  always_comb begin
    next_r = r;
    // Odd or oversized values behave as zero
    next_r.dwords = line_ok(line_size) ? line_size[PREFETCH_W-1:0]
                                       : '0;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prefetch_dwords = r.dwords;
endmodule // bcsr_line_decode

// ---- src/bcsr_regs.sv ----
// Bridge primary status, class/revision and line size configuration registers
// Function
// - Poisoned TLP sets detected poison flag
// - Sent error message with enable sets flag
// - Unsupported-request completion sets its flag
// - Completer-abort completion received sets flag
// - Completing with completer abort sets flag
// - Parity enable gates master poison flag
// - Error flags stay set until cleared
// - Select timing bits read zero
// - Unused capability and reserved bits zero
// - Capability list bit reads one
// - Class fields read bridge codes
// - Low byte shows silicon revision
// - Class register ignores writes
// - Line size sets prefetch length
// - Odd or oversized line size means zero
// - System error enable gates reports, resets off
// - Parity enable never blocks poison forwarding
`timescale 1ns/100ps
module bcsr_regs
  import bcsr_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION = 8'h5a // Arbitrary value
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  CFG_RD,
  input  wire logic                  CFG_WR,
  input  wire logic [7:0]            CFG_ADDR,
  input  wire logic [3:0]            CFG_BE,
  input  wire logic [31:0]           CFG_WDATA,
  output logic      [31:0]           CFG_RDATA,
  output logic                       CFG_ACK,
  input  wire logic                  EV_POISON_TLP,
  input  wire logic                  EV_ERR_MSG_REQ,
  input  wire logic                  EV_CPL_UNSUP,
  input  wire logic                  EV_CPL_CABORT,
  input  wire logic                  EV_CABORT_SENT,
  input  wire logic                  EV_POISON_CPL,
  input  wire logic                  EV_POISON_WR,
  output logic                       ERR_MSG_SEND,
  output logic                       FWD_BAD_PARITY,
  output logic                       SERR_ENABLE,
  output logic                       PARITY_RESPONSE,
  output logic      [PREFETCH_W-1:0] PREFETCH_DWORDS
);
  import bcsr_pkg::*;

  // ==========================================
  // State
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        serr_en;
    logic        par_en;
    logic [7:0]  line_size;
    logic        err_send;
    logic        fwd_bad;
  } bcsr_top_s;

  bcsr_top_s   r;
  bcsr_top_s   next_r;
  logic [15:0] flags;
  logic [15:0] flag_set;
  logic [15:0] flag_clr;
  logic [15:0] status_img;
  logic [15:0] command_img;
  logic [31:0] class_img;
  logic [5:0]  idx;
  logic        wr_cmdst;
  logic        wr_line;

  // ==========================================
  // Decode
  assign idx      = CFG_ADDR[7:2];
  assign wr_cmdst = CFG_WR && (idx == OFF_COMMAND[7:2]);
  assign wr_line  = CFG_WR && (idx == OFF_LINE_SIZE[7:2]) && CFG_BE[0];

  // ==========================================
  // Error flags
  always_comb begin
    flag_set                 = '0;
    flag_set[BIT_DET_POISON] = EV_POISON_TLP;
    flag_set[BIT_SIG_SYSERR] = EV_ERR_MSG_REQ && r.serr_en;
    flag_set[BIT_RCV_UNSUP]  = EV_CPL_UNSUP;
    flag_set[BIT_RCV_CABORT] = EV_CPL_CABORT;
    flag_set[BIT_SIG_CABORT] = EV_CABORT_SENT;
    flag_set[BIT_MST_POISON] = r.par_en && (EV_POISON_CPL || EV_POISON_WR);
  end

  // Only error positions can be cleared, and only by ones
  always_comb begin
    flag_clr = '0;
    if (wr_cmdst) begin
      flag_clr[15:8] = CFG_BE[3] ? CFG_WDATA[31:24] : 8'h00;
      flag_clr[7:0]  = CFG_BE[2] ? CFG_WDATA[23:16] : 8'h00;
    end
    flag_clr = flag_clr & STATUS_ERR_MASK;
  end

  bcsr_sticky #(
    .WIDTH (16)
  ) u_sticky (
    .REF_CLK (REF_CLK),
    .SYS_RST (SYS_RST),
    .set     (flag_set),
    .clr     (flag_clr),
    .q       (flags)
  );

  // ==========================================
  // Read images
  // Constant bits come from the reset image; timing and reserved
  // bits stay zero, and the capability list bit reads one
  assign status_img = (flags & STATUS_ERR_MASK) | STATUS_RST;

  always_comb begin
    command_img                = COMMAND_RST;
    command_img[BIT_SERR_EN]   = r.serr_en;
    command_img[BIT_PARITY_EN] = r.par_en;
  end

  assign class_img = {BASE_CLASS, SUB_CLASS, PROG_IF, SILICON_REVISION};

  // ==========================================
  // Register updates
  always_comb begin
    next_r     = r;
    next_r.ack = CFG_RD || CFG_WR;
    if (CFG_RD) begin
      unique case (idx)
        OFF_COMMAND[7:2]:   next_r.rdata = {status_img, command_img};
        OFF_CLASS[7:2]:     next_r.rdata = class_img;
        OFF_LINE_SIZE[7:2]: next_r.rdata = {24'h000000, r.line_size};
        default:            next_r.rdata = 32'h00000000;
      endcase
    end
    // Writes to the class word fall through with no effect
    if (wr_cmdst && CFG_BE[1]) begin
      next_r.serr_en = CFG_WDATA[BIT_SERR_EN];
    end
    if (wr_cmdst && CFG_BE[0]) begin
      next_r.par_en = CFG_WDATA[BIT_PARITY_EN];
    end
    if (wr_line) begin
      next_r.line_size = CFG_WDATA[7:0];
    end
    next_r.err_send = EV_ERR_MSG_REQ && r.serr_en;
    next_r.fwd_bad  = EV_POISON_TLP;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      r           <= '0;
      r.line_size <= LINE_SIZE_RST;
    end else begin
      r <= next_r;
    end
  end

  bcsr_line_decode u_line (
    .REF_CLK         (REF_CLK),
    .SYS_RST         (SYS_RST),
    .line_size       (r.line_size),
    .prefetch_dwords (PREFETCH_DWORDS)
  );

  // ==========================================
  // Outputs
  assign CFG_RDATA       = r.rdata;
  assign CFG_ACK         = r.ack;
  assign ERR_MSG_SEND    = r.err_send;
  assign FWD_BAD_PARITY  = r.fwd_bad;
  assign SERR_ENABLE     = r.serr_en;
  assign PARITY_RESPONSE = r.par_en;

  // ==========================================
  // Assertions
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_rd_status;
    CFG_RD && (idx == OFF_COMMAND[7:2]);
  endsequence

  sequence s_rd_class;
    CFG_RD && (idx == OFF_CLASS[7:2]);
  endsequence

  property p_det_poison;
    EV_POISON_TLP |=> flags[BIT_DET_POISON] && FWD_BAD_PARITY;
  endproperty
  a_det_poison: assert property (p_det_poison)
    else $error("poison flag or forwarding missing");

  property p_signaled_system_error_flag;
    EV_ERR_MSG_REQ && SERR_ENABLE |=> ERR_MSG_SEND && flags[BIT_SIG_SYSERR];
  endproperty
  a_signaled_system_error_flag: assert property (p_signaled_system_error_flag)
    else $error("system error not sent or flagged");

  property p_no_report;
    !SERR_ENABLE |=> !ERR_MSG_SEND;
  endproperty
  a_no_report: assert property (p_no_report)
    else $error("error reported while disabled");

  property p_rx_flags;
    EV_CPL_UNSUP && EV_CPL_CABORT |=> flags[BIT_RCV_UNSUP] && flags[BIT_RCV_CABORT];
  endproperty
  a_rx_flags: assert property (p_rx_flags)
    else $error("received completion flag missing");

  property p_sig_cabort;
    EV_CABORT_SENT |=> flags[BIT_SIG_CABORT];
  endproperty
  a_sig_cabort: assert property (p_sig_cabort)
    else $error("signaled abort flag missing");

  property p_mst_poison;
    $rose(flags[BIT_MST_POISON]) |-> $past(PARITY_RESPONSE);
  endproperty
  a_mst_poison: assert property (p_mst_poison)
    else $error("master poison set while disabled");

  property p_sticky;
    flags[BIT_DET_POISON] && !flag_clr[BIT_DET_POISON] |=> flags[BIT_DET_POISON];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag lost without clear");

  property p_w1c;
    wr_cmdst && CFG_BE[3] && CFG_WDATA[31] && !EV_POISON_TLP
      |=> !flags[BIT_DET_POISON] ##1 flags[BIT_DET_POISON] == $past(EV_POISON_TLP);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  property p_status_ro;
    s_rd_status |=> CFG_ACK && CFG_RDATA[20] && (CFG_RDATA[26:25] == 2'b00)
      && (CFG_RDATA[23:21] == 3'b000) && (CFG_RDATA[19:16] == 4'h0);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status constant bits wrong");

  property p_class;
    s_rd_class |=> CFG_ACK && (CFG_RDATA == {8'h06, 8'h04, 8'h00, SILICON_REVISION});
  endproperty
  a_class: assert property (p_class)
    else $error("class register value wrong");

  property p_line_odd;
    r.line_size[0] || (r.line_size > LINE_SIZE_MAX) |=> PREFETCH_DWORDS == '0;
  endproperty
  a_line_odd: assert property (p_line_odd)
    else $error("odd line size gives prefetch");

  property p_line_ok;
    (r.line_size == 8'h10) [*2] |=> PREFETCH_DWORDS == 6'd16;
  endproperty
  a_line_ok: assert property (p_line_ok)
    else $error("prefetch does not follow line size");

  property p_syserr_gate;
    $rose(flags[BIT_SIG_SYSERR]) |-> $past(SERR_ENABLE);
  endproperty
  a_syserr_gate: assert property (p_syserr_gate)
    else $error("system error flag set while disabled");

  property p_rcv_unsup;
    EV_CPL_UNSUP |=> flags[BIT_RCV_UNSUP];
  endproperty
  a_rcv_unsup: assert property (p_rcv_unsup)
    else $error("unsupported completion flag missing");

  property p_rcv_cabort;
    EV_CPL_CABORT |=> flags[BIT_RCV_CABORT];
  endproperty
  a_rcv_cabort: assert property (p_rcv_cabort)
    else $error("received abort flag missing");

  property p_mst_set;
    PARITY_RESPONSE && (EV_POISON_CPL || EV_POISON_WR) |=> flags[BIT_MST_POISON];
  endproperty
  a_mst_set: assert property (p_mst_set)
    else $error("master poison flag missing");

  property p_fwd_cause;
    FWD_BAD_PARITY |-> $past(EV_POISON_TLP);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause)
    else $error("bad parity forwarded without poison");

  property p_ack_pulse;
    CFG_RD || CFG_WR |=> CFG_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("access not acknowledged");

  property p_ack_idle;
    !(CFG_RD || CFG_WR) |=> !CFG_ACK;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("acknowledge without access");
endmodule // bcsr_regs

// ---- verification/bcsr_link_model.sv ----
// Upstream link model that turns commanded events into one-cycle pulses
`timescale 1ns/100ps
module bcsr_link_model (
  input  wire logic       ref_clk,
  input  wire logic [6:0] kick,
  output logic      [6:0] ev
);
  logic [6:0] pend = 7'h00;
  initial ev = 7'h00;
  // ==========================================
  // Events move off the sampling edge and last exactly one cycle
  always @(posedge ref_clk) pend <= kick;
  always @(negedge ref_clk) ev <= pend;
endmodule // bcsr_link_model

// ---- verification/bcsr_regs_tb.sv ----
// Self-checking bench for the status, class and line size registers
`timescale 1ns/100ps
module bcsr_regs_tb;
  import bcsr_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // Arbitrary value
  logic                  ref_clk;
  logic                  sys_rst;
  logic                  cfg_rd;
  logic                  cfg_wr;
  logic                  cfg_ack;
  logic [7:0]            cfg_addr;
  logic [3:0]            cfg_be;
  logic [31:0]           cfg_wdata;
  logic [31:0]           cfg_rdata;
  logic [6:0]            kick;
  logic [6:0]            ev;
  logic                  err_msg_send;
  logic                  fwd_bad_parity;
  logic                  serr_enable;
  logic                  parity_response;
  logic [PREFETCH_W-1:0] prefetch;
  logic                  serr;
  logic                  par;
  logic [15:0]           st;
  logic [31:0]           d;
  logic [31:0]           q;
  logic [7:0]            b;
  int                    k;
  int                    n_fail = 0;
  int                    samples_checked = 0;
  // Corner line sizes, valid ones first, then odd and oversized
  logic [7:0] ls [13] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h06,
                          8'h01, 8'h21, 8'h22, 8'h40, 8'hff, 8'h1f};

  bcsr_link_model LINK (.ref_clk(ref_clk), .kick(kick), .ev(ev));

  bcsr_regs #(.SILICON_REVISION(REV)) DUT (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CFG_RD(cfg_rd), .CFG_WR(cfg_wr),
    .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
    .CFG_ACK(cfg_ack), .EV_POISON_TLP(ev[0]), .EV_ERR_MSG_REQ(ev[1]), .EV_CPL_UNSUP(ev[2]),
    .EV_CPL_CABORT(ev[3]), .EV_CABORT_SENT(ev[4]), .EV_POISON_CPL(ev[5]),
    .EV_POISON_WR(ev[6]), .ERR_MSG_SEND(err_msg_send), .FWD_BAD_PARITY(fwd_bad_parity),
    .SERR_ENABLE(serr_enable), .PARITY_RESPONSE(parity_response), .PREFETCH_DWORDS(prefetch)
  );

  // ==========================================
  // Expectations
  function automatic logic [15:0] exp_set(logic [6:0] v, logic s, logic p);
    return {v[0], v[1] & s, v[2], v[3], v[4], 2'b00, (v[5] | v[6]) & p, 8'h00};
  endfunction

  function automatic logic [PREFETCH_W-1:0] exp_pf(logic [7:0] v);
    return (v[0] || v > LINE_SIZE_MAX) ? '0 : v[PREFETCH_W-1:0];
  endfunction

  // ==========================================
  // Shared tasks
  task automatic give_verdict();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] dat, output logic [31:0] r);
    int i;
    @(negedge ref_clk);
    cfg_rd = !wr;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = dat;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    for (i = 0; i < 4 && cfg_ack !== 1'b1; i++) @(negedge ref_clk);
    if (cfg_ack === 1'b1) begin
      r = cfg_rdata;
    end else begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    cfg(1'b0, a, 4'h0, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic fire(input logic [6:0] v);
    @(negedge ref_clk);
    kick = v;
    @(negedge ref_clk);
    kick = 7'h00;
    @(negedge ref_clk);
    chk(err_msg_send, v[1] & serr);
    chk(fwd_bad_parity, v[0]);
    st = st | exp_set(v, serr, par);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata, kick} = '0;
    {serr, par, st} = '0;
    void'($urandom(32'h5ec8));
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    rdchk(OFF_STATUS, {STATUS_RST, COMMAND_RST});
    rdchk(OFF_CLASS, {BASE_CLASS, SUB_CLASS, PROG_IF, REV});
    rdchk(OFF_LINE_SIZE, {24'h0, LINE_SIZE_RST});
    rdchk(8'h40, 32'h0);
    chk({serr_enable, parity_response, prefetch}, '0);
    cfg(1'b1, OFF_CLASS, 4'hf, $urandom, q);
    rdchk(OFF_CLASS, {BASE_CLASS, SUB_CLASS, PROG_IF, REV});
    $display("test reset and read-only done");
    for (k = 0; k < 40; k++) begin
      d = $urandom;
      cfg(1'b1, OFF_COMMAND, 4'h3, d, q);
      serr = d[BIT_SERR_EN];
      par = d[BIT_PARITY_EN];
      chk({serr_enable, parity_response}, {serr, par});
      fire((k < 3) ? 7'h7f : 7'($urandom));
      rdchk(OFF_STATUS, {st | STATUS_RST, 7'h00, serr, 1'b0, par, 6'h00});
      d = (k % 4 == 0) ? 32'h0 : $urandom;
      cfg(1'b1, OFF_STATUS, 4'hc, d, q);
      st = st & ~(d[31:16] & STATUS_ERR_MASK);
    end
    rdchk(OFF_STATUS, {st | STATUS_RST, 7'h00, serr, 1'b0, par, 6'h00});
    $display("test error flags done");
    for (k = 0; k < 20; k++) begin
      b = (k < 13) ? ls[k] : 8'($urandom);
      cfg(1'b1, OFF_LINE_SIZE, 4'h1, {24'($urandom), b}, q);
      @(negedge ref_clk);
      chk(prefetch, exp_pf(b));
      cfg(1'b1, OFF_LINE_SIZE, 4'he, 32'hffffffff, q);
      rdchk(OFF_LINE_SIZE, {24'h0, b});
    end
    $display("test line size done");
    give_verdict();
  end
endmodule // bcsr_regs_tb
